// File: logic/io_cell_regs.sv
// Purpose: Storage and pad control of one programmable I/O cell, APB configured.
// Assumes: Fabric and pad inputs synchronous to pclk; clocks arrive as levels.
// Notes:   Pad is three signals; resistors are enable outputs only.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Six storage elements: two input, two output, two tristate.
// - Each element is a flip-flop or a transparent latch.
// - DDR uses two clocks on one edge, kept opposite by the clock source.
// - DDR paths carry two data alternately, one per clock edge.
// - Each element has its own set level and initial value.
// - One sync/async set-reset choice for the whole cell.
// - Every control input has its own selectable polarity.
// - Options none, sync set/reset/both, async preset/clear/both.
// - Sync set and reset together give reset.
// - Async preset and clear together give clear.
// - Pulls on every standard; keeper only LVTTL, LVCMOS, PCI.
// - Keeper holds last pad level when all drivers are off.
// - Pull-up or pull-down overrides the keeper.
// - Drive programmable to 24 mA; 1.8 V and 1.5 V capped at 16 mA.
// - Controlled-impedance standards have no drive or slew selection.
// - Before configuration done, the pad driver is off.
// - Before configuration done, pull-down and keeper are off.
// - Before configuration, swap pin low turns pull-ups on.
// - Input selection kept in two cells; output needs both to agree.
module io_cell_regs
  import io_cell_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        clk_a,
  input  wire logic        clk_b,
  input  wire logic        ce_in,
  input  wire logic        sr_in,
  input  wire logic        rev_in,
  input  wire logic        out_en_in,
  input  wire logic        out_a,
  input  wire logic        out_b,
  input  wire logic        ts_a,
  input  wire logic        ts_b,
  output logic             in_a,
  output logic             in_b,
  input  wire logic        preconfig_pullup_disable_pin,
  input  wire logic        pad_i,
  output logic             pad_o,
  output logic             pad_oe,
  output logic             pullup_en,
  output logic             pulldown_en,
  output logic             keeper_en,
  output logic             keeper_o,
  output logic [2:0]       drive_sel,
  output logic             slew_fast
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [31:0] cell_cfg_q, cell_cfg_d;
  logic [31:0] elem0_q, elem0_d;
  logic [31:0] elem1_q, elem1_d;
  logic [31:0] pad_cfg_q, pad_cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic        keep_q, keep_d;
  logic        clka_q, clka_d;
  logic        clkb_q, clkb_d;
  logic        done_q, done_d;

  logic [NUM_ELEMS*ELEM_FW-1:0] elem_cfg;
  logic [5:0]  pol;
  logic        ca, cb, ce_p, sr_p, rev_p, oen_p;
  logic        edge_a, edge_b;
  logic        sync_sr, ddr_in, ddr_out, ddr_ts;
  logic        input_only;
  logic [NUM_ELEMS-1:0] q;
  logic [NUM_ELEMS-1:0] dval;
  logic [NUM_ELEMS-1:0] edges;
  logic [NUM_ELEMS-1:0] gates;
  logic        out_sel, ts_sel;
  logic        wr, rd, mapped;
  pad_std_t    std;
  logic        keeper_ok, cap16, no_drive;
  logic [2:0]  drv_req;

  assign elem_cfg = {elem1_q[15:0], elem0_q};
  assign sync_sr  = cell_cfg_q[CELL_SYNC_SR_BIT];
  assign ddr_in   = cell_cfg_q[CELL_DDR_BIT];
  assign ddr_out  = cell_cfg_q[CELL_DDR_BIT+1];
  assign ddr_ts   = cell_cfg_q[CELL_DDR_BIT+2];
  assign pol      = cell_cfg_q[CELL_POL_BIT+5:CELL_POL_BIT];

  // ************************************************************
  // Control polarity; inversion folded into an XOR per input
  // ************************************************************
  assign ca    = clk_a ^ pol[0];
  assign cb    = clk_b ^ pol[1];
  assign ce_p  = ce_in ^ pol[2];
  assign sr_p  = sr_in ^ pol[3];
  assign rev_p = rev_in ^ pol[4];
  assign oen_p = out_en_in ^ pol[5];

  // Rising edges of the two phase clocks, sampled on pclk
  assign edge_a = ca && !clka_q;
  assign edge_b = cb && !clkb_q;

  // ************************************************************
  // Input selection held in two cells; either cell selects input, output needs both
  // ************************************************************
  assign input_only = cell_cfg_q[CELL_IN_SEL_A_BIT] || cell_cfg_q[CELL_IN_SEL_B_BIT];

  // ************************************************************
  // Per-element data and clocking; B elements use clk_b in DDR
  // ************************************************************
  assign dval = {ts_b, ts_a, out_b, out_a, pad_i, pad_i};

  always_comb
  begin
    edges = {ddr_ts ? edge_b : edge_a, edge_a,
             ddr_out ? edge_b : edge_a, edge_a,
             ddr_in ? edge_b : edge_a, edge_a};
    gates = {ddr_ts ? cb : ca, ca, ddr_out ? cb : ca, ca, ddr_in ? cb : ca, ca};
  end

  // Six elements, each with its own slice of configuration
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ELEMS; gi = gi + 1)
    begin : g_elem
      io_storage_elem u_elem (
        .pclk        (pclk),
        .presetn     (presetn),
        .is_latch    (elem_cfg[gi*ELEM_FW+EF_LATCH]),
        .sr_mode     (elem_cfg[gi*ELEM_FW+EF_SR_MODE +: 2]),
        .forces_high (elem_cfg[gi*ELEM_FW+EF_FORCES_HIGH]),
        .init_one    (elem_cfg[gi*ELEM_FW+EF_INIT_ONE]),
        .sync_sr     (sync_sr),
        .load_init   (!done_q),
        .clk_edge    (edges[gi]),
        .gate_open   (gates[gi]),
        .ce          (ce_p),
        .set_in      (rev_p),
        .rst_in      (sr_p),
        .d           (dval[gi]),
        .q           (q[gi])
      );
    end
  endgenerate

  // ************************************************************
  // DDR output mux: selects the element clocked most recently
  // ************************************************************
  assign out_sel = ddr_out && !ca;
  assign ts_sel  = ddr_ts && !ca;

  // ************************************************************
  // Pad standard decode
  // ************************************************************
  always_comb
  begin
    std       = pad_std_t'(pad_cfg_q[PAD_STD_BIT +: 4]);
    keeper_ok = (std == STD_LVTTL) || (std == STD_LVCMOS33) || (std == STD_LVCMOS25) ||
                (std == STD_LVCMOS18) || (std == STD_LVCMOS15) || (std == STD_PCI);
    cap16     = (std == STD_LVCMOS18) || (std == STD_LVCMOS15);
    no_drive  = (std == STD_CI_LVCMOS) || (std == STD_HALF_CI);
    drv_req   = pad_cfg_q[PAD_DRIVE_BIT +: 3];
    if (drv_req > DRV_24MA)
    begin
      drv_req = DRV_24MA;
    end
    if (cap16 && drv_req > DRV_16MA)
    begin
      drv_req = DRV_16MA;
    end
  end

  // ************************************************************
  // APB slave: zero wait states, error on unmapped address
  // ************************************************************
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && !penable && !pwrite;  // Setup cycle: data ready for the access edge
  assign mapped = (paddr == OFS_CELL_CFG) || (paddr == OFS_ELEM_CFG0) || (paddr == OFS_ELEM_CFG1) ||
                  (paddr == OFS_PAD_CFG) || (paddr == OFS_STATUS);

  always_comb
  begin
    cell_cfg_d = cell_cfg_q;
    elem0_d    = elem0_q;
    elem1_d    = elem1_q;
    pad_cfg_d  = pad_cfg_q;
    rdata_d    = rdata_q;
    clka_d     = ca;
    clkb_d     = cb;
    if (wr)
    begin
      case (paddr)
        OFS_CELL_CFG:  cell_cfg_d = {18'h00000, pwdata[13:0]};
        OFS_ELEM_CFG0: elem0_d    = pwdata;
        OFS_ELEM_CFG1: elem1_d    = {16'h0000, pwdata[15:0]};
        OFS_PAD_CFG:   pad_cfg_d  = {20'h00000, pwdata[11:0]};
        default:       ;
      endcase
    end
    if (rd)
    begin
      case (paddr)
        OFS_CELL_CFG:  rdata_d = cell_cfg_q;
        OFS_ELEM_CFG0: rdata_d = elem0_q;
        OFS_ELEM_CFG1: rdata_d = elem1_q;
        OFS_PAD_CFG:   rdata_d = pad_cfg_q;
        OFS_STATUS:    rdata_d = {24'h000000, keep_q, pad_i, q};
        default:       rdata_d = 32'h00000000;
      endcase
    end
    done_d = cell_cfg_d[CELL_DONE_BIT];
  end

  // ************************************************************
  // Keeper memory: follows the pad while anything drives it
  // ************************************************************
  always_comb
  begin
    keep_d = pad_i;
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_cfg_q <= 32'h00000000;
      elem0_q    <= 32'h00000000;
      elem1_q    <= 32'h00000000;
      pad_cfg_q  <= {20'h00000, 1'b0, DRV_RESET, 8'h00};
      rdata_q    <= 32'h00000000;
      keep_q     <= 1'b0;
      clka_q     <= 1'b0;
      clkb_q     <= 1'b0;
      done_q     <= 1'b0;
    end
    else
    begin
      cell_cfg_q <= cell_cfg_d;
      elem0_q    <= elem0_d;
      elem1_q    <= elem1_d;
      pad_cfg_q  <= pad_cfg_d;
      rdata_q    <= rdata_d;
      keep_q     <= keep_d;
      clka_q     <= clka_d;
      clkb_q     <= clkb_d;
      done_q     <= done_d;
    end
  end

  // Read data registered in the setup cycle, so no wait state is needed
  assign pready  = !psel || !penable || rd_ready();
  assign prdata  = rdata_q;
  // Error shown in the access phase itself, where the master samples it
  assign pslverr = !mapped && pready && psel && penable;

  function automatic logic rd_ready();
    rd_ready = 1'b1;
  endfunction : rd_ready

  // ************************************************************
  // Pad outputs
  // ************************************************************
  always_comb
  begin
    in_a        = q[E_IN_A];
    in_b        = ddr_in ? q[E_IN_B] : q[E_IN_A];
    pad_o       = out_sel ? q[E_OUT_B] : q[E_OUT_A];
    // Tristate element high means driver off; disabled until done
    pad_oe      = done_q && !input_only && oen_p &&
                  !(ts_sel ? q[E_TS_B] : q[E_TS_A]);
    pullup_en   = done_q ? pad_cfg_q[PAD_PULLUP_BIT] : !preconfig_pullup_disable_pin;
    pulldown_en = done_q && pad_cfg_q[PAD_PULLDN_BIT];
    keeper_en   = done_q && keeper_ok && pad_cfg_q[PAD_KEEPER_BIT] &&
                  !pullup_en && !pulldown_en;
    keeper_o    = keep_q;
    drive_sel   = no_drive ? DRV_RESET : drv_req;
    slew_fast   = !no_drive && pad_cfg_q[PAD_SLEW_BIT];
  end

endmodule : io_cell_regs
`default_nettype wire

// File: shared/io_cell_pkg.sv
// Purpose: Constants and types for the programmable I/O cell logic.
// Assumes: APB register access, 32-bit data, one clock (pclk).
// Notes:   Offsets are byte addresses of aligned words.
package io_cell_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFS_CELL_CFG   = 8'h00;
  localparam logic [7:0] OFS_ELEM_CFG0  = 8'h04;
  localparam logic [7:0] OFS_ELEM_CFG1  = 8'h08;
  localparam logic [7:0] OFS_PAD_CFG    = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;

  // ************************************************************
  // Cell configuration fields
  // ************************************************************
  localparam int CELL_SYNC_SR_BIT  = 0;
  localparam int CELL_DONE_BIT     = 1;
  localparam int CELL_IN_SEL_A_BIT = 2;
  localparam int CELL_IN_SEL_B_BIT = 3;
  localparam int CELL_DDR_BIT      = 4;  // 3 bits: input, output, tristate
  localparam int CELL_POL_BIT      = 8;  // 6 bits: clk_a, clk_b, ce, sr, rev, out_en_in

  // ************************************************************
  // Per-element fields, 8 bits per element
  // ************************************************************
  localparam int NUM_ELEMS      = 6;
  localparam int ELEM_FW        = 8;
  localparam int EF_LATCH       = 0;
  localparam int EF_SR_MODE     = 1;  // 2 bits
  localparam int EF_FORCES_HIGH = 3;
  localparam int EF_INIT_ONE    = 4;

  // Set/reset modes of one element
  localparam logic [1:0] SR_NONE = 2'h0;
  localparam logic [1:0] SR_SET  = 2'h1;
  localparam logic [1:0] SR_RST  = 2'h2;
  localparam logic [1:0] SR_BOTH = 2'h3;

  // ************************************************************
  // Pad configuration fields
  // ************************************************************
  localparam int PAD_PULLUP_BIT   = 0;
  localparam int PAD_PULLDN_BIT   = 1;
  localparam int PAD_KEEPER_BIT   = 2;
  localparam int PAD_STD_BIT      = 4;  // 4 bits
  localparam int PAD_DRIVE_BIT    = 8;  // 3 bits
  localparam int PAD_SLEW_BIT     = 11;

  // Signalling standards
  typedef enum logic [3:0] {
    STD_LVTTL     = 4'h0,
    STD_LVCMOS33  = 4'h1,
    STD_LVCMOS25  = 4'h2,
    STD_LVCMOS18  = 4'h3,
    STD_LVCMOS15  = 4'h4,
    STD_PCI       = 4'h5,
    STD_CI_LVCMOS = 4'h6,
    STD_HALF_CI   = 4'h7,
    STD_OTHER     = 4'h8
  } pad_std_t;

  // Drive codes 2,4,6,8,12,16,24 mA
  localparam logic [2:0] DRV_16MA = 3'h5;
  localparam logic [2:0] DRV_24MA = 3'h6;
  localparam logic [2:0] DRV_RESET = 3'h3;

  // Element indices
  localparam int E_IN_A  = 0;
  localparam int E_IN_B  = 1;
  localparam int E_OUT_A = 2;
  localparam int E_OUT_B = 3;
  localparam int E_TS_A  = 4;
  localparam int E_TS_B  = 5;

endpackage : io_cell_pkg

// File: logic/io_storage_elem.sv
// Purpose: One storage element of the I/O cell: flip-flop or latch with set/reset.
// Assumes: Controls already polarity-corrected; runs on pclk.
// Notes:   Latch mode is modelled as transparency sampled each pclk.
`timescale 1ns/1ps
`default_nettype none
module io_storage_elem
  import io_cell_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       is_latch,
  input  wire logic [1:0] sr_mode,
  input  wire logic       forces_high,
  input  wire logic       init_one,
  input  wire logic       sync_sr,
  input  wire logic       load_init,
  input  wire logic       clk_edge,
  input  wire logic       gate_open,
  input  wire logic       ce,
  input  wire logic       set_in,
  input  wire logic       rst_in,
  input  wire logic       d,
  output logic            q
);

  logic q_q;
  logic q_d;
  logic set_ok;
  logic rst_ok;

  // ************************************************************
  // Next value
  // ************************************************************
  always_comb
  begin
    set_ok = set_in && (sr_mode == SR_SET || sr_mode == SR_BOTH);
    rst_ok = rst_in && (sr_mode == SR_RST || sr_mode == SR_BOTH);
    q_d    = q_q;
    if (load_init)
    begin
      q_d = init_one;
    end
    else if (!sync_sr && rst_ok)
    begin
      q_d = 1'b0;
    end
    else if (!sync_sr && set_ok)
    begin
      q_d = forces_high;
    end
    else if (is_latch ? gate_open : clk_edge)
    begin
      if (sync_sr && rst_ok)
      begin
        q_d = 1'b0;
      end
      else if (sync_sr && set_ok)
      begin
        q_d = forces_high;
      end
      else if (ce)
      begin
        q_d = d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_q <= 1'b0;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule : io_storage_elem
`default_nettype wire

// File: tb/io_cell_chk.sv
// Purpose: Port checks for the I/O cell logic
// Assumes: Config words shadowed from APB writes
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module io_cell_chk
  import io_cell_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        preconfig_pullup_disable_pin,
  input wire logic        pad_oe,
  input wire logic        pullup_en,
  input wire logic        pulldown_en,
  input wire logic        keeper_en,
  input wire logic [2:0]  drive_sel
);
  logic [31:0] cfg_q, cfg_d, pad_q, pad_d;
  logic        wr, done;
  logic [3:0]  std;
  // ********
  // Shadow
  // ********
  // Taken at the access edge, same edge as the design
  always_comb
  begin
    wr    = psel && penable && pwrite;
    cfg_d = (wr && paddr == OFS_CELL_CFG) ? pwdata : cfg_q;
    pad_d = (wr && paddr == OFS_PAD_CFG) ? pwdata : pad_q;
    done  = cfg_q[CELL_DONE_BIT];
    std   = pad_q[PAD_STD_BIT +: 4];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= 32'h0;
      pad_q <= 32'h300;
    end
    else
    begin
      cfg_q <= cfg_d;
      pad_q <= pad_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********
  // Checks
  // ********
  property p_hiz; !done |-> !pad_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("driver on before done");
  property p_pre_off; !done |-> !pulldown_en && !keeper_en; endproperty
  a_pre_off: assert property (p_pre_off) else $error("pull-down or keeper before done");
  property p_swap; !done |-> pullup_en == !preconfig_pullup_disable_pin; endproperty
  a_swap: assert property (p_swap) else $error("pull-up not set by swap pin");
  property p_in_sel; cfg_q[CELL_IN_SEL_A_BIT] || cfg_q[CELL_IN_SEL_B_BIT] |-> !pad_oe; endproperty
  a_in_sel: assert property (p_in_sel) else $error("input pad driven");
  property p_keep_std; keeper_en |-> std <= 4'h5; endproperty
  a_keep_std: assert property (p_keep_std) else $error("keeper on bad standard");
  property p_keep_pull; pullup_en || pulldown_en |-> !keeper_en; endproperty
  a_keep_pull: assert property (p_keep_pull) else $error("keeper beside a pull");
  property p_keep_on;
    done && pad_q[PAD_KEEPER_BIT] && pad_q[1:0] == 2'h0 && std <= 4'h5 |-> keeper_en;
  endproperty
  a_keep_on: assert property (p_keep_on) else $error("keeper missing");
  property p_pull_cfg; done |-> {pulldown_en, pullup_en} == pad_q[1:0]; endproperty
  a_pull_cfg: assert property (p_pull_cfg) else $error("pulls differ from config");
  property p_drv16; done && (std == STD_LVCMOS18 || std == STD_LVCMOS15) |-> drive_sel <= DRV_16MA; endproperty
  a_drv16: assert property (p_drv16) else $error("drive above 16 mA");
  property p_drv24; done |-> drive_sel <= DRV_24MA; endproperty
  a_drv24: assert property (p_drv24) else $error("drive above 24 mA");
  c_done: cover property (wr && paddr == OFS_CELL_CFG && pwdata[CELL_DONE_BIT]);
  c_keep: cover property (keeper_en);
  c_pull: cover property (done && pullup_en);
endmodule : io_cell_chk
`default_nettype wire

// File: tb/io_pad_model.sv
// Purpose: Pad and board seen from the I/O cell
// Assumes: One optional board driver
// Notes:   A floating pad wobbles every cycle
`timescale 1ns/1ps
`default_nettype none
module io_pad_model
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pad_o,
  input  wire logic pad_oe,
  input  wire logic pullup_en,
  input  wire logic pulldown_en,
  input  wire logic keeper_en,
  input  wire logic keeper_o,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pad_i
);
  logic wob_q;
  // Pattern so an undriven pad never settles by chance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wob_q <= 1'b0;
    else
      wob_q <= !wob_q;
  end
  // Cell driver first, then board, resistors, keeper
  always_comb
  begin
    if (pad_oe)
      pad_i = pad_o;
    else if (ext_en)
      pad_i = ext_val;
    else if (pullup_en)
      pad_i = 1'b1;
    else if (pulldown_en)
      pad_i = 1'b0;
    else if (keeper_en)
      pad_i = keeper_o;
    else
      pad_i = wob_q;
  end
endmodule : io_pad_model
`default_nettype wire

// File: tb/io_cell_regs_tb_top.sv
// Purpose: Self-checking bench for the I/O cell logic
// Assumes: Zero-wait APB, read data taken at the access edge
// Notes:   Element state read back through status
`timescale 1ns/1ps
`default_nettype none
module io_cell_regs_tb_top
  import io_cell_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ra, cfg;
  logic        clk_a, clk_b, ce_in, sr_in, rev_in, out_en_in, out_a, out_b, ts_a, ts_b;
  logic        in_a, in_b, preconfig_pullup_disable_pin, pad_i, pad_o, pad_oe;
  logic        pullup_en, pulldown_en, keeper_en, keeper_o, slew_fast, ext_en, ext_val;
  logic [2:0]  drive_sel;
  int          mismatches, compares, seed, regs [5];
  io_cell_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .clk_a, .clk_b, .ce_in, .sr_in, .rev_in, .out_en_in, .out_a, .out_b, .ts_a, .ts_b,
    .in_a, .in_b, .preconfig_pullup_disable_pin, .pad_i, .pad_o, .pad_oe, .pullup_en, .pulldown_en,
    .keeper_en, .keeper_o, .drive_sel, .slew_fast);
  io_pad_model i_pad (.pclk, .presetn, .pad_o, .pad_oe, .pullup_en, .pulldown_en, .keeper_en,
    .keeper_o, .ext_en, .ext_val, .pad_i);
  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 16)
      mismatches++;
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge between transfers
    @(posedge pclk);
    if (w)
      regs[a[4:2]] = d;
  endtask : apb
  task automatic rdchk(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
    check("rdata", regs[a[4:2]], rd);
  endtask : rdchk
  // Clock levels held two cycles so the edge is seen
  task automatic pulse(input logic b);
    if (b)
      clk_b <= 1'b1;
    else
      clk_a <= 1'b1;
    repeat (2) @(posedge pclk);
    clk_a <= 1'b0;
    clk_b <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse
  // ********
  // Sequence
  // ********
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    results();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, clk_a, clk_b, sr_in, rev_in} = '0;
    {out_a, out_b, ts_a, ts_b, preconfig_pullup_disable_pin, ext_en, ext_val} = '0;
    {ce_in, out_en_in} = 2'h3;
    mismatches = 0;
    compares = 0;
    seed = 32'h64a26e95;
    regs = '{0, 0, 0, 32'h300, 0};
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check("pullup_en", 1'b1, pullup_en);
    rdchk(OFS_CELL_CFG);
    rdchk(OFS_PAD_CFG);
    apb(8'h14, 1'b0, 32'h0);
    check("pslverr", 1'b1, err);
    preconfig_pullup_disable_pin <= 1'b1;
    @(posedge pclk);
    check("pullup_en", 1'b0, pullup_en);
    // Initial values per element while not configured
    apb(OFS_ELEM_CFG0, 1'b1, 32'h1000);
    apb(OFS_ELEM_CFG1, 1'b1, 32'h10);
    rdchk(OFS_ELEM_CFG1);
    apb(OFS_STATUS, 1'b0, 32'h0);
    check("init", {regs[2][12], regs[2][4], regs[1][28], regs[1][20], regs[1][12], regs[1][4]}, rd[5:0]);
    apb(OFS_ELEM_CFG0, 1'b1, 32'h0);
    apb(OFS_ELEM_CFG1, 1'b1, 32'h0);
    cfg = 32'h1 << CELL_DONE_BIT | 32'h1 << (CELL_DDR_BIT + 1) | 32'h1 << CELL_IN_SEL_A_BIT;
    apb(OFS_CELL_CFG, 1'b1, cfg);
    ext_en <= 1'b1;
    // Output pair alternates on opposite clocks
    repeat (4)
    begin
      ra = $random(seed);
      out_a <= ra[0];
      out_b <= ra[1];
      ts_a <= ra[2];
      ext_val <= ra[3];
      pulse(1'b0);
      pulse(1'b1);
      apb(OFS_STATUS, 1'b0, 32'h0);
      check("ddr", {ra[2], ra[1], ra[0], ra[3]}, {rd[4:2], rd[0]});
      check("in_a", ra[3], in_a);
    end
    // Sync set and reset together, then async
    // Set forces high, so a wrong priority shows as a one
    apb(OFS_ELEM_CFG0, 1'b1, {12'h000, 1'b1, SR_BOTH, 17'h00000});
    for (int s = 1; s >= 0; s--)
    begin
      apb(OFS_CELL_CFG, 1'b1, cfg | s);
      out_a <= 1'b1;
      pulse(1'b0);
      sr_in <= 1'b1;
      rev_in <= 1'b1;
      if (s)
        pulse(1'b0);
      else
        repeat (3) @(posedge pclk);
      apb(OFS_STATUS, 1'b0, 32'h0);
      check("sr_both", 1'b0, rd[2]);
      sr_in <= 1'b0;
      rev_in <= 1'b0;
    end
    // Latch follows data while its gate is open
    apb(OFS_ELEM_CFG0, 1'b1, 32'h1 << (2 * ELEM_FW + EF_LATCH));
    clk_a <= 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      out_a <= v[0];
      repeat (3) @(posedge pclk);
      apb(OFS_STATUS, 1'b0, 32'h0);
      check("latch", v[0], rd[2]);
    end
    clk_a <= 1'b0;
    // Inverted enable: low input enables, high holds
    apb(OFS_ELEM_CFG0, 1'b1, 32'h0);
    apb(OFS_CELL_CFG, 1'b1, cfg | 32'h1 << (CELL_POL_BIT + 2));
    for (int c = 0; c < 2; c++)
    begin
      ce_in <= c[0];
      out_a <= !c[0];
      pulse(1'b0);
      apb(OFS_STATUS, 1'b0, 32'h0);
      check("ce_pol", 1'b1, rd[2]);
    end
    // Keeper and drive per standard
    for (int s = 0; s < 9; s++)
    begin
      apb(OFS_PAD_CFG, 1'b1, 32'h604 | s << PAD_STD_BIT);
      check("keeper_en", s <= 5, keeper_en);
      if (s <= 5 && s != 3 && s != 4)
        check("drive_sel", DRV_24MA, drive_sel);
      else if (s == 3 || s == 4)
        check("drive_sel", DRV_16MA, drive_sel);
      else if (s == 6 || s == 7)
        check("slew_fast", 1'b0, slew_fast);
    end
    apb(OFS_PAD_CFG, 1'b1, 32'h5);
    check("keep_pull", 2'h1, {keeper_en, pullup_en});
    rdchk(OFS_PAD_CFG);
    // Second reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    regs = '{0, 0, 0, 32'h300, 0};
    rdchk(OFS_CELL_CFG);
    results();
  end
endmodule : io_cell_regs_tb_top
bind io_cell_regs io_cell_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .preconfig_pullup_disable_pin, .pad_oe, .pullup_en, .pulldown_en, .keeper_en, .drive_sel);
`default_nettype wire
